// *** logic/adcseq_core.sv ***
// conversion sequencer: APB registers, mode sequencing, timing, calibration and interrupts
`timescale 1ns/1ps
module adcseq_core
    import adcseq_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = CAL_RESET_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic      [3:0]          mux_chan,
    output logic                     sample_hold,
    output logic                     conv_start,
    input  wire logic [RES_W-1:0]    conv_data,
    input  wire logic [NUM_CHAN-1:0] port_pin,
    output logic                     irq
);
    localparam int unsigned TW = 16;

    logic [31:0]         ctrl;
    logic [15:0]         scan_sel;
    logic [RES_W-1:0]    result;
    logic [3:0]          result_chan;
    logic                result_full;
    logic [RES_W-1:0]    hold_buf;
    logic [3:0]          hold_chan;
    logic                hold_valid;
    logic [RES_W-1:0]    inj_result;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [31:0]         cal_left;
    logic                cal_active;
    logic                running;
    logic                inj_pending;
    logic                inj_now;
    logic [3:0]          cur_chan;
    logic [NUM_CHAN-1:0] pin_s1;
    logic [NUM_CHAN-1:0] pin_s2;
    adcseq_state_t       state;
    adcseq_state_t       next_state;
    logic                tload;
    logic [TW-1:0]       tcount;
    logic                tdone;

    // bus decode
    wire         apb_acc   = psel & penable;
    wire         apb_wr    = apb_acc & pwrite;
    wire         apb_rd    = apb_acc & ~pwrite;
    wire         hit_ctrl  = paddr == OFF_CTRL;
    wire         hit_res   = paddr == OFF_RESULT;
    wire         hit_inj   = paddr == OFF_INJ;
    wire         hit_stat  = paddr == OFF_STAT;
    wire         hit_istat = paddr == OFF_IRQ_STAT;
    wire         hit_imask = paddr == OFF_IRQ_MASK;
    wire         hit_scan  = paddr == OFF_SCAN;
    wire         hit_din   = paddr == OFF_DIN;
    wire         addr_ok   = hit_ctrl | hit_res | hit_inj | hit_stat | hit_istat | hit_imask | hit_scan | hit_din;
    wire         res_read  = apb_rd & hit_res;
    wire         start_wr  = apb_wr & hit_ctrl & pwdata[F_START];
    wire         stop_wr   = apb_wr & hit_ctrl & pwdata[F_STOP];
    wire         inj_wr    = apb_wr & hit_ctrl & pwdata[F_INJ_REQ];

    // control fields
    wire [3:0]   sel_chan  = ctrl[F_CHAN +: 4];
    wire [1:0]   mode      = ctrl[F_MODE +: 2];
    wire         wait_for_read_enable    = ctrl[F_WAIT];
    // a control write that starts a conversion also sets its clocks and channel
    wire [31:0]  cfg       = (apb_wr & hit_ctrl) ? pwdata : ctrl;
    wire [1:0]   conversion_clock_select = cfg[F_CTC +: 2];
    wire [1:0]   sample_clock_select     = cfg[F_STC +: 2];
    wire [3:0]   inj_chan  = ctrl[F_INJ_CHAN +: 4];
    wire         scanning  = mode[1];
    wire         continuous = mode[0];

    // conversion clock period in base periods; code 01 is reserved, treated as 00
    wire [7:0]   tcc = (conversion_clock_select == 2'b10) ? 8'(CC_TCL_10) :
                       (conversion_clock_select == 2'b11) ? 8'(CC_TCL_11) : 8'(CC_TCL_00);
    wire [11:0]  tsc = 12'(tcc) << sample_clock_select;
    // the timer runs one cycle past its load, so each phase loads its length minus one
    wire [TW-1:0] sample_cyc = TW'(CONV_SC) * TW'(tsc) - TW'(1);
    wire [TW-1:0] conv_cyc   = TW'(CONV_CC) * TW'(tcc) - TW'(1);
    wire [TW-1:0] xfer_cyc   = TW'(CONV_TCL) - TW'(1);
    wire [TW-1:0] cal_cyc    = TW'(CAL_CC) * TW'(tcc) - TW'(1);

    // next scanned channel: next lower selected channel; scan_more stays low when none below is selected, no wrap
    logic [3:0]  scan_next;
    logic        scan_more;
    always_comb begin
        scan_next = cur_chan;
        scan_more = 1'b0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (i < cur_chan && scan_sel[i] && !scan_more) begin
                scan_next = 4'(i);
                scan_more = 1'b1;
            end
        end
    end

    wire         conv_end  = (state == ST_XFER) & tdone;
    wire         cal_end   = (state == ST_CAL) & tdone;
    wire         hold_free = ~result_full | res_read;
    wire         go_on     = running & (continuous | (scanning & scan_more));
    wire [3:0]   first_chan = cfg[F_CHAN +: 4];

    always_comb begin
        next_state = state;
        tload      = 1'b0;
        tcount     = '0;
        case (state)
            ST_IDLE: begin
                if (start_wr || (inj_pending && running)) begin
                    next_state = ST_SAMPLE;
                    tload      = 1'b1;
                    tcount     = sample_cyc;
                end
            end
            ST_SAMPLE: begin
                if (tdone) begin
                    next_state = ST_CONV;
                    tload      = 1'b1;
                    tcount     = conv_cyc;
                end
            end
            ST_CONV: begin
                if (tdone) begin
                    next_state = ST_XFER;
                    tload      = 1'b1;
                    tcount     = xfer_cyc;
                end
            end
            ST_XFER: begin
                if (tdone) begin
                    next_state = ST_CAL;
                    tload      = 1'b1;
                    tcount     = cal_cyc;
                end
            end
            ST_CAL: begin
                if (tdone) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!(hold_valid && wait_for_read_enable)) begin
                    if (inj_pending || go_on) begin
                        next_state = ST_SAMPLE;
                        tload      = 1'b1;
                        tcount     = sample_cyc;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    adcseq_timer #(
        .W (TW)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tload),
        .count   (tcount),
        .done    (tdone),
        .running ()
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // sequencing of channel, run flag and injection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running     <= 1'b0;
            inj_pending <= 1'b0;
            inj_now     <= 1'b0;
            cur_chan    <= 4'h0;
        end else begin
            if (inj_wr && running && continuous) begin
                inj_pending <= 1'b1;
            end
            if (start_wr && state == ST_IDLE) begin
                running  <= 1'b1;
                cur_chan <= first_chan;
            end else if (stop_wr) begin
                running  <= 1'b0;
            end
            if (tload && next_state == ST_SAMPLE && state != ST_IDLE) begin
                if (inj_pending) begin
                    inj_now     <= 1'b1;
                    inj_pending <= 1'b0;
                end else if (scanning) begin
                    cur_chan <= scan_more ? scan_next : sel_chan;
                end
            end else if (tload && next_state == ST_SAMPLE && inj_pending) begin
                inj_now     <= 1'b1;
                inj_pending <= 1'b0;
            end
            if (cal_end && inj_now) begin
                inj_now <= 1'b0;
            end
            if (next_state == ST_IDLE && state == ST_HOLD) begin
                running <= 1'b0;
            end
        end
    end

    // result register, wait-for-read buffer, injection result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result      <= '0;
            result_chan <= 4'h0;
            result_full <= 1'b0;
            hold_buf    <= '0;
            hold_chan   <= 4'h0;
            hold_valid  <= 1'b0;
            inj_result  <= '0;
        end else begin
            if (res_read) begin
                result_full <= 1'b0;
            end
            if (hold_valid && hold_free) begin
                result      <= hold_buf;
                result_chan <= hold_chan;
                result_full <= 1'b1;
                hold_valid  <= 1'b0;
            end
            if (conv_end) begin
                if (inj_now) begin
                    inj_result <= conv_data;
                end else if (wait_for_read_enable && continuous && result_full && !res_read) begin
                    hold_buf   <= conv_data;
                    hold_chan  <= cur_chan;
                    hold_valid <= 1'b1;
                end else begin
                    result      <= conv_data;
                    result_chan <= cur_chan;
                    result_full <= 1'b1;
                end
            end
        end
    end

    // reset calibration, lengthened while conversions use the converter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_left   <= 32'(CAL_CYCLES);
            cal_active <= 1'b1;
        end else if (cal_active) begin
            if (state == ST_IDLE || state == ST_HOLD) begin
                cal_left   <= cal_left - 32'd1;
                cal_active <= cal_left > 32'd1;
            end
        end
    end

    // interrupts: sticky, write one to clear, set wins
    wire [IRQ_W-1:0] irq_set;
    assign irq_set[IRQ_DONE] = conv_end & ~inj_now;
    assign irq_set[IRQ_OVR]  = conv_end & ~inj_now & result_full & ~res_read
                             & ~(wait_for_read_enable & continuous);
    assign irq_set[IRQ_INJ]  = conv_end & inj_now;
    wire [IRQ_W-1:0] irq_clr = (apb_wr & hit_istat) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
            ctrl     <= CTRL_RESET;
            scan_sel <= SCAN_RESET;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq      <= |(irq_stat & irq_mask);
            if (apb_wr && hit_imask) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
            if (apb_wr && hit_scan) begin
                scan_sel <= pwdata[15:0];
            end
            if (apb_wr && hit_ctrl) begin
                ctrl <= pwdata & 32'h0000_FFBF;
            end
        end
    end

    // digital read of channel pins not converted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= port_pin;
            pin_s2 <= pin_s1;
        end
    end

    wire       busy = cal_active | (state != ST_IDLE);
    wire [3:0] drive_chan = inj_now ? inj_chan : cur_chan;
    wire [31:0] rd_mux =
        hit_ctrl  ? ctrl :
        hit_res   ? {16'h0000, result_chan, 2'b00, result} :
        hit_inj   ? {16'h0000, inj_chan, 2'b00, inj_result} :
        hit_stat  ? {28'h000_0000, hold_valid, result_full, running, busy} :
        hit_istat ? {29'h0000_0000, irq_stat} :
        hit_imask ? {29'h0000_0000, irq_mask} :
        hit_scan  ? {16'h0000, scan_sel} :
        hit_din   ? {16'h0000, pin_s2} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            mux_chan    <= 4'h0;
            sample_hold <= 1'b0;
            conv_start  <= 1'b0;
        end else begin
            pready      <= psel & ~penable;
            pslverr     <= psel & ~penable & ~addr_ok;
            prdata      <= rd_mux;
            mux_chan    <= drive_chan;
            // strobes trail the state by one edge so mux_chan settles with them
            sample_hold <= state == ST_SAMPLE;
            conv_start  <= sample_hold & (state != ST_SAMPLE);
        end
    end
endmodule : adcseq_core

// *** logic/adcseq_pkg.sv ***
// package: register map, field layout and timing constants of the conversion sequencer
package adcseq_pkg;
    localparam int unsigned NUM_CHAN       = 16;
    localparam int unsigned RES_W          = 10;
    localparam int unsigned CLK_MHZ        = 100;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL        = 8'h00;
    localparam logic [7:0] OFF_RESULT      = 8'h04;
    localparam logic [7:0] OFF_INJ         = 8'h08;
    localparam logic [7:0] OFF_STAT        = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT    = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h14;
    localparam logic [7:0] OFF_SCAN        = 8'h18;
    localparam logic [7:0] OFF_DIN         = 8'h1C;
    // converter_control_register fields
    localparam int unsigned F_CHAN         = 0;   // 4 bits
    localparam int unsigned F_MODE         = 4;   // 2 bits
    localparam int unsigned F_START        = 6;
    localparam int unsigned F_WAIT         = 7;
    localparam int unsigned F_CTC          = 8;   // 2 bits
    localparam int unsigned F_STC          = 10;  // 2 bits
    localparam int unsigned F_INJ_CHAN     = 12;  // 4 bits
    localparam int unsigned F_INJ_REQ      = 16;
    localparam int unsigned F_STOP         = 17;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [15:0] SCAN_RESET     = 16'h0000;
    // interrupt bits
    localparam int unsigned IRQ_DONE       = 0;
    localparam int unsigned IRQ_OVR        = 1;
    localparam int unsigned IRQ_INJ        = 2;
    localparam int unsigned IRQ_W          = 3;
    // timing, in half_oscillator_period units: base period = 1 pclk
    localparam int unsigned CC_TCL_00      = 24;
    localparam int unsigned CC_TCL_10      = 96;
    localparam int unsigned CC_TCL_11      = 48;
    localparam int unsigned CONV_CC        = 14;
    localparam int unsigned CONV_SC        = 2;
    localparam int unsigned CONV_TCL       = 4;
    localparam int unsigned CAL_CC         = 4;
    localparam real         CAL_RESET_MS   = 1.6;
    localparam int unsigned CAL_RESET_CYC  = int'($ceil(CAL_RESET_MS * 1000.0 * CLK_MHZ));
    typedef enum logic [1:0] {
        ADCSEQ_SINGLE      = 2'b00,
        ADCSEQ_CONTINUOUS  = 2'b01,
        ADCSEQ_SCAN_SINGLE = 2'b10,
        ADCSEQ_SCAN_CONT   = 2'b11
    } adcseq_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_CONV   = 3'b010,
        ST_XFER   = 3'b011,
        ST_CAL    = 3'b100,
        ST_HOLD   = 3'b101
    } adcseq_state_t;
endpackage : adcseq_pkg

// *** logic/adcseq_timer.sv ***
// timer: down counter loaded with a cycle count, pulses done when it expires
`timescale 1ns/1ps
module adcseq_timer #(
    parameter int unsigned W = 12
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              done,
    output logic              running
);
    logic [W-1:0] remain;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain  <= '0;
            done    <= 1'b0;
            running <= 1'b0;
        end else if (load) begin
            remain  <= count;
            done    <= 1'b0;
            running <= 1'b1;
        end else if (running) begin
            remain  <= remain - 1'b1;
            done    <= (remain == {{(W-1){1'b0}}, 1'b1});
            running <= (remain != {{(W-1){1'b0}}, 1'b1});
        end else begin
            done    <= 1'b0;
        end
    end
endmodule : adcseq_timer

// *** verif/adcseq_conv_model.sv ***
// model: analog multiplexer and converter core answering each conversion start
`timescale 1ns/1ps
module adcseq_conv_model
    import adcseq_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [3:0]       mux_chan,
    input  wire logic             sample_hold,
    input  wire logic             conv_start,
    output logic      [RES_W-1:0] conv_data
);
    // value depends on the latched channel; scrambled while sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            conv_data <= 10'h3ff;
        else if (conv_start)
            conv_data <= {mux_chan, mux_chan[1:0], mux_chan};
        else if (sample_hold)
            conv_data <= ~conv_data;
    end
endmodule : adcseq_conv_model

// *** verif/adcseq_core_checker.sv ***
// checker: port timing of the conversion sequencer
`timescale 1ns/1ps
module adcseq_core_checker (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [3:0] mux_chan,
    input wire logic       sample_hold,
    input wire logic       conv_start
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [11:0] sh_cnt;
    logic [11:0] since_conv;
    // sample length and distance from the last conversion start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_cnt     <= 12'h000;
            since_conv <= 12'hfff;
        end else begin
            sh_cnt     <= sample_hold ? sh_cnt + 12'h001 : 12'h000;
            since_conv <= conv_start ? 12'h000 : (since_conv == 12'hfff) ? since_conv : since_conv + 12'h001;
        end
    end
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready) else $error("pready late");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr alone");
    AST_MUX_STABLE: assert property (sample_hold && $past(sample_hold) |-> $stable(mux_chan))
        else $error("channel moved in sampling");
    AST_CONV_AFTER_SAMPLE: assert property ($fell(sample_hold) |-> ##[0:1] conv_start)
        else $error("no conversion start after sampling");
    AST_NO_OVERLAP: assert property (conv_start |-> !sample_hold) else $error("sampling in conversion");
    AST_SAMPLE_LEN: assert property ($fell(sample_hold) |-> sh_cnt inside {48, 96, 192, 384, 768, 1536})
        else $error("bad sampling length");
    AST_CAL_GAP: assert property ($rose(sample_hold) |-> since_conv >= 12'd436)
        else $error("next sample too soon");
    C_CONV: cover property (conv_start);
    C_ERR: cover property (pslverr);
    C_LONG: cover property ($fell(sample_hold) && sh_cnt == 12'd192);
endmodule : adcseq_core_checker
bind adcseq_core adcseq_core_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .mux_chan(mux_chan), .sample_hold(sample_hold), .conv_start(conv_start));

// *** verif/adc_conversion_sequencer_tb_top.sv ***
// testbench: register-level scenarios for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top import adcseq_pkg::*;;
    logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0000_0000, prdata, rd_q, lfsr_q = 32'h0000_38ad;
    logic                pready, pslverr, sample_hold, conv_start, irq, err_q;
    logic [3:0]          mux_chan, ch;
    logic [RES_W-1:0]    conv_data;
    logic [NUM_CHAN-1:0] port_pin = 16'h0000, scan;
    int                  failures = 0, total_checks = 0;
    always #5 pclk = ~pclk;
    adcseq_core #(.CAL_CYCLES(50)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mux_chan(mux_chan), .sample_hold(sample_hold), .conv_start(conv_start), .conv_data(conv_data),
        .port_pin(port_pin), .irq(irq));
    adcseq_conv_model u_model (.pclk(pclk), .presetn(presetn), .mux_chan(mux_chan),
        .sample_hold(sample_hold), .conv_start(conv_start), .conv_data(conv_data));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic [31:0] exp_res(input logic [3:0] c);
        return {16'h0000, c, 2'b00, c, c[1:0], c};
    endfunction : exp_res
    task automatic test_done;
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("apb_ready", 32'(n), 0);
    endtask : apb
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
        int n;
        n = 0;
        apb(1'b0, a, 32'h0);
        while ((rd_q & m) !== want && n < 3000) begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        check("poll", rd_q & m, want);
    endtask : poll
    task automatic conv_once(input logic [1:0] ctc, input logic [1:0] stc, input logic msk);
        int len;
        int tcc;
        len = 0;
        tcc = (ctc == 2'b10) ? 96 : (ctc == 2'b11) ? 48 : 24;
        apb(1'b1, OFF_IRQ_MASK, {31'h0, msk});
        apb(1'b1, OFF_CTRL, {20'h0, stc, ctc, 2'b01, 2'b00, ch});
        while (sample_hold !== 1'b1 && len < 50) begin
            @(posedge pclk);
            len++;
        end
        len = 0;
        while (sample_hold === 1'b1 && len < 4000) begin
            @(posedge pclk);
            len++;
        end
        check("sample_len", 32'(len), 32'((2 * tcc) << stc));
        poll(OFF_IRQ_STAT, 32'h1, 32'h1);
        apb(1'b0, OFF_RESULT, 32'h0);
        check("single_result", rd_q, exp_res(ch));
        poll(OFF_STAT, 32'h3, 32'h0);
        check("irq_level", {31'h0, irq}, {31'h0, msk});
        apb(1'b1, OFF_IRQ_STAT, 32'h1);
        repeat (3) @(posedge pclk);
        check("irq_clear", {31'h0, irq}, 32'h0);
    endtask : conv_once
    initial begin
        #500_000;
        failures++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl_reset", rd_q, CTRL_RESET);
        apb(1'b0, OFF_SCAN, 32'h0);
        check("scan_reset", rd_q, {16'h0, SCAN_RESET});
        repeat (20) @(posedge pclk);
        apb(1'b0, OFF_STAT, 32'h0);
        check("busy_cal", rd_q & 32'h1, 32'h1);
        poll(OFF_STAT, 32'h1, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped_err", {31'h0, err_q}, 32'h1);
        check("unmapped_data", rd_q, 32'h0);
        lfsr_q = lfsr_next(lfsr_q);
        port_pin <= lfsr_q[15:0];
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_DIN, 32'h0);
        check("pins", rd_q, {16'h0, port_pin});
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            ch = lfsr_q[3:0];
            conv_once(i < 3 ? 2'(i + (i > 0)) : 2'b00, i < 3 ? 2'b00 : 2'(i - 2), 1'(i != 5));
        end
        ch = lfsr_q[7:4];
        apb(1'b1, OFF_CTRL, {24'h0, 2'b01, 2'b01, ch});
        poll(OFF_IRQ_STAT, 32'h2, 32'h2);
        apb(1'b1, OFF_CTRL, {15'h0, 1'b1, ~ch, 6'h0, 2'b01, ch});
        poll(OFF_IRQ_STAT, 32'h4, 32'h4);
        apb(1'b0, OFF_INJ, 32'h0);
        check("inj_result", rd_q, exp_res(~ch));
        apb(1'b1, OFF_IRQ_STAT, 32'h7);
        apb(1'b0, OFF_RESULT, 32'h0);
        poll(OFF_STAT, 32'h4, 32'h4);
        apb(1'b0, OFF_RESULT, 32'h0);
        check("cont_result", rd_q, exp_res(ch));
        apb(1'b1, OFF_CTRL, 32'h0002_0000);
        poll(OFF_STAT, 32'h3, 32'h0);
        apb(1'b1, OFF_CTRL, {24'h0, 2'b11, 2'b01, ch});
        poll(OFF_STAT, 32'h8, 32'h8);
        repeat (1200) @(posedge pclk);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        check("no_overrun", rd_q & 32'h2, 32'h0);
        apb(1'b0, OFF_RESULT, 32'h0);
        check("held_result", rd_q, exp_res(ch));
        apb(1'b1, OFF_CTRL, 32'h0002_0000);
        poll(OFF_STAT, 32'h3, 32'h0);
        apb(1'b0, OFF_RESULT, 32'h0);
        scan = {4'h0, 1'b1, lfsr_q[10:0]};
        apb(1'b1, OFF_SCAN, {16'h0, scan});
        apb(1'b1, OFF_CTRL, {24'h0, 2'b01, 2'b10, 4'hb});
        for (int k = 11; k >= 0; k--) begin
            if (scan[k]) begin
                poll(OFF_STAT, 32'h4, 32'h4);
                apb(1'b0, OFF_RESULT, 32'h0);
                check("scan_result", rd_q, exp_res(4'(k)));
            end
        end
        poll(OFF_STAT, 32'h3, 32'h0);
        test_done();
    end
endmodule : adc_conversion_sequencer_tb_top
